// ==== src/wdg_pkg.sv ====
// Package of the digital watchdog: register map, field layout, reset values,
// divider counts and the bus carrier types.
// Assumes a single 25 MHz clock that stands for the internal clock.
package wdg_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte addresses.
	localparam logic [7:0] OFF_WDCC = 8'hD8;
	localparam logic [7:0] OFF_STAT = 8'hDC;
	localparam logic [7:0] OFF_CLR = 8'hE0;
	localparam logic [7:0] OFF_EN = 8'hE4;
	localparam logic [7:0] OFF_STATE = 8'hE8;

	// Count and control register layout.
	localparam logic [7:0] WDCC_RST = 8'hFE;
	localparam int BIT_CTRL = 0;
	localparam int BIT_SR = 1;
	localparam int CNT_LO = 2;
	localparam int CNT_W = 7;

	// Clock division: internal clock by 12, then by 256 per count step.
	localparam int DIV_INT = 12;
	localparam int DIV_PRE = 256;
	localparam int STAB_CYCLES = 2048;

	// Event bits of the status, clear and enable registers.
	localparam int EV_W = 3;
	localparam int EV_TIMER = 0;
	localparam int EV_WDRST = 1;
	localparam int EV_STOPWAIT = 2;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [0:0] {
		PWR_RUN = 1'b0,
		PWR_STOP = 1'b1
	} wdg_pwr_e;

	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} wdg_axi_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} wdg_axi_rsp_s;

endpackage : wdg_pkg

// ==== src/wdg_rst_hold.sv ====
// Reset stretcher: holds the device reset while its source is high and for a
// fixed number of clock cycles after the source falls.
// Assumes the source already contains the external reset, so its own state
// is defined from the first cycle of any reset.
`timescale 1ns/1ps
`default_nettype none

module wdg_rst_hold #(
	parameter int HOLD = wdg_pkg::STAB_CYCLES
) (
	input wire logic clk,
	input wire logic src,
	output logic hold_r
);

	localparam int CW = $clog2(HOLD + 1);
	localparam logic [CW-1:0] HOLD_C = CW'(HOLD);

	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic hold_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		hold_nxt = 1'b0;
		if (src) begin
			cnt_nxt = '0;
			hold_nxt = 1'b1;
		end else if (cnt_r < HOLD_C) begin
			// The reset stays asserted until the full settle count has run.
			cnt_nxt = cnt_r + CW'(1);
			hold_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		cnt_r <= cnt_nxt;
		hold_r <= hold_nxt;
	end

endmodule : wdg_rst_hold

`default_nettype wire

// ==== src/wdg_top.sv ====
// Digital watchdog with its AXI4-Lite register slave, reset generation and
// stop-mode gating.
// Assumes clk is the internal clock and that the core drives stop_req and
// wake as one-cycle pulses synchronous to it.
//
// Operation
// - Missed refresh asserts device reset, reinitialising counter.
// - Watchdog reset restarts like pin reset, with delay.
// - Reset held 2048 cycles after source release.
// - Counter clocked from internal clock divided by twelve.
// - Active watchdog resets when the count steps below zero, clearing the soft-reset bit.
// - Software option: inactive until activation bit written.
// - Activation sticks until the next device reset.
// - Hardware option: activation bit reads one, fixed.
// - Hardware option: STOP runs as WAIT, counting continues.
// - Stop allowed only while inactive under software option.
// - Counting resumes when stop mode is left.
// - Register resets to 0xFE: inactive, longest period.
// - Soft-reset bit cleared, by write or count, resets.
// - Count bits reversed: bit 7 LSB, bit 2 MSB.
// - Six count bits give 64 periods, 3072 to 196608.
// - Inactive counter is a seven-bit timer, soft-reset MSB.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module wdg_top #(
	parameter int DIV_INT = wdg_pkg::DIV_INT,
	parameter int DIV_PRE = wdg_pkg::DIV_PRE,
	parameter int STAB_CYCLES = wdg_pkg::STAB_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic hw_option,
	input wire logic stop_req,
	input wire logic wake,
	input wire wdg_pkg::wdg_axi_req_s axi_req,
	output wdg_pkg::wdg_axi_rsp_s axi_rsp,
	output logic dev_rst_r,
	output logic irq_r,
	output logic stop_lp_r,
	output logic stop_as_wait_r
);

	localparam int IW = $clog2(DIV_INT);
	localparam int PW = $clog2(DIV_PRE);
	localparam logic [IW-1:0] INT_LAST = IW'(DIV_INT - 1);
	localparam logic [PW-1:0] PRE_LAST = PW'(DIV_PRE - 1);
	localparam logic [7:0] RST_VAL = wdg_pkg::WDCC_RST;

	// Mirrors six count bits end for end; the register and the counter
	// hold them in opposite order.
	function automatic logic [5:0] rev6(input logic [5:0] x);
		logic [5:0] y;
		y = '0;
		for (int i = 0; i < 6; i++) begin
			y[i] = x[5-i];
		end
		return y;
	endfunction : rev6

	// ---------------------------------------------------------------------
	// Option strap, caught while the external reset is applied.
	logic hw_opt_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			hw_opt_r <= hw_option;
		end
	end

	// ---------------------------------------------------------------------
	// Bus slave state.
	wdg_pkg::wdg_axi_rsp_s rsp_r;
	wdg_pkg::wdg_axi_rsp_s rsp_nxt;
	logic aw_have_r;
	logic aw_have_nxt;
	logic w_have_r;
	logic w_have_nxt;
	logic [7:0] awaddr_r;
	logic [7:0] awaddr_nxt;
	logic [31:0] wdata_r;
	logic [31:0] wdata_nxt;
	logic wstrb0_r;
	logic wstrb0_nxt;
	logic do_wr;
	logic wr_wdcc;
	logic wr_clr;
	logic wr_en;

	// Watchdog state.
	logic [6:0] cnt_r;
	logic [6:0] cnt_nxt;
	logic active_r;
	logic active_nxt;
	logic [IW-1:0] div_r;
	logic [IW-1:0] div_nxt;
	logic [PW-1:0] pre_r;
	logic [PW-1:0] pre_nxt;
	logic fire_r;
	logic fire_nxt;
	logic tick;
	logic [6:0] cnt_dec;
	logic msb_fall;
	logic wd_clr;

	// Power state.
	wdg_pkg::wdg_pwr_e pwr_r;
	wdg_pkg::wdg_pwr_e pwr_nxt;
	logic stop_lp_nxt;
	logic stop_as_wait_nxt;

	// Event registers.
	logic [2:0] stat_r;
	logic [2:0] stat_nxt;
	logic [2:0] en_r;
	logic [2:0] en_nxt;
	logic [2:0] ev;
	logic irq_nxt;

	logic [31:0] rd_data;
	logic rd_hit;

	assign axi_rsp = rsp_r;

	// ---------------------------------------------------------------------
	// Read multiplexer; the active bit reads one under the hardware option.
	always_comb begin
		rd_data = '0;
		rd_hit = 1'b1;
		case (axi_req.araddr)
			wdg_pkg::OFF_WDCC: begin
				rd_data[7:wdg_pkg::CNT_LO] = rev6(cnt_r[5:0]);
				rd_data[wdg_pkg::BIT_SR] = cnt_r[6];
				rd_data[wdg_pkg::BIT_CTRL] = active_r | hw_opt_r;
			end
			wdg_pkg::OFF_STAT: rd_data[2:0] = stat_r;
			wdg_pkg::OFF_CLR: rd_data = '0;
			wdg_pkg::OFF_EN: rd_data[2:0] = en_r;
			wdg_pkg::OFF_STATE: rd_data[2:0] = {stop_lp_r, hw_opt_r, active_r};
			default: rd_hit = 1'b0;
		endcase
	end

	// Bus handshakes: address and data are taken in either order, the write
	// happens once both are held and no response is outstanding.
	always_comb begin
		rsp_nxt = rsp_r;
		aw_have_nxt = aw_have_r;
		w_have_nxt = w_have_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb0_nxt = wstrb0_r;
		do_wr = aw_have_r & w_have_r & ~rsp_r.bvalid;
		if (axi_req.awvalid & rsp_r.awready) begin
			aw_have_nxt = 1'b1;
			awaddr_nxt = axi_req.awaddr;
		end
		if (axi_req.wvalid & rsp_r.wready) begin
			w_have_nxt = 1'b1;
			wdata_nxt = axi_req.wdata;
			wstrb0_nxt = axi_req.wstrb[0];
		end
		if (rsp_r.bvalid & axi_req.bready) begin
			rsp_nxt.bvalid = 1'b0;
		end
		if (do_wr) begin
			aw_have_nxt = 1'b0;
			w_have_nxt = 1'b0;
			rsp_nxt.bvalid = 1'b1;
			case (awaddr_r)
				wdg_pkg::OFF_WDCC,
				wdg_pkg::OFF_CLR,
				wdg_pkg::OFF_EN: rsp_nxt.bresp = wdg_pkg::RESP_OKAY;
				default: rsp_nxt.bresp = wdg_pkg::RESP_SLVERR;
			endcase
		end
		rsp_nxt.awready = ~aw_have_nxt & ~rsp_nxt.bvalid;
		rsp_nxt.wready = ~w_have_nxt & ~rsp_nxt.bvalid;
		if (rsp_r.rvalid & axi_req.rready) begin
			rsp_nxt.rvalid = 1'b0;
		end
		if (axi_req.arvalid & rsp_r.arready) begin
			rsp_nxt.rvalid = 1'b1;
			rsp_nxt.rdata = rd_data;
			rsp_nxt.rresp = rd_hit ? wdg_pkg::RESP_OKAY : wdg_pkg::RESP_SLVERR;
		end
		rsp_nxt.arready = ~rsp_nxt.rvalid;
	end

	assign wr_wdcc = do_wr & wstrb0_r & (awaddr_r == wdg_pkg::OFF_WDCC);
	assign wr_clr = do_wr & wstrb0_r & (awaddr_r == wdg_pkg::OFF_CLR);
	assign wr_en = do_wr & wstrb0_r & (awaddr_r == wdg_pkg::OFF_EN);

	always_ff @(posedge clk) begin
		if (rst) begin
			rsp_r <= '0;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb0_r <= 1'b0;
		end else begin
			rsp_r <= rsp_nxt;
			aw_have_r <= aw_have_nxt;
			w_have_r <= w_have_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb0_r <= wstrb0_nxt;
		end
	end

	// ---------------------------------------------------------------------
	// Counter. The prescaler freezes in low-power stop, as the oscillator
	// that feeds it would be halted there.
	assign tick = (div_r == INT_LAST) & (pre_r == PRE_LAST) &
		(pwr_r == wdg_pkg::PWR_RUN);
	assign cnt_dec = cnt_r - 7'h01;
	assign msb_fall = tick & cnt_r[6] & ~cnt_dec[6];
	// The device reset also clears the watchdog itself.
	assign wd_clr = rst | dev_rst_r;

	always_comb begin
		cnt_nxt = cnt_r;
		active_nxt = active_r | hw_opt_r;
		div_nxt = div_r;
		pre_nxt = pre_r;
		fire_nxt = 1'b0;
		if (pwr_r == wdg_pkg::PWR_RUN) begin
			div_nxt = (div_r == INT_LAST) ? '0 : div_r + IW'(1);
			if (div_r == INT_LAST) begin
				// Wrap explicitly so a prescale count that is not a power
				// of two still gives the intended step length.
				pre_nxt = (pre_r == PRE_LAST) ? '0 :
					pre_r + PW'(1);
			end
		end
		if (tick) begin
			cnt_nxt = cnt_dec;
		end
		if (active_r & msb_fall) begin
			fire_nxt = 1'b1;
		end
		if (wr_wdcc) begin
			// A write reloads the count and restarts the prescaler.
			cnt_nxt[5:0] = rev6(wdata_r[7:wdg_pkg::CNT_LO]);
			cnt_nxt[6] = wdata_r[wdg_pkg::BIT_SR];
			div_nxt = '0;
			pre_nxt = '0;
			// Writing zero never clears activation.
			active_nxt = active_r | hw_opt_r | wdata_r[wdg_pkg::BIT_CTRL];
			fire_nxt = active_nxt & ~wdata_r[wdg_pkg::BIT_SR];
		end
	end

	always_ff @(posedge clk) begin
		if (wd_clr) begin
			cnt_r <= RST_VAL[7:1];
			active_r <= RST_VAL[0];
			div_r <= '0;
			pre_r <= '0;
			fire_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			active_r <= active_nxt;
			div_r <= div_nxt;
			pre_r <= pre_nxt;
			fire_r <= fire_nxt;
		end
	end

	// A watchdog firing goes through the same stretcher as the external
	// reset, so both get the full settle delay.
	wdg_rst_hold #(
		.HOLD(STAB_CYCLES)
	) u_hold (
		.clk(clk),
		.src(rst | fire_r),
		.hold_r(dev_rst_r)
	);

	// ---------------------------------------------------------------------
	// Stop handling.
	always_comb begin
		pwr_nxt = pwr_r;
		stop_as_wait_nxt = 1'b0;
		case (pwr_r)
			wdg_pkg::PWR_RUN: begin
				if (stop_req) begin
					if (~active_r & ~hw_opt_r) begin
						pwr_nxt = wdg_pkg::PWR_STOP;
					end else begin
						stop_as_wait_nxt = 1'b1;
					end
				end
			end
			wdg_pkg::PWR_STOP: begin
				if (wake) begin
					pwr_nxt = wdg_pkg::PWR_RUN;
				end
			end
			default: pwr_nxt = wdg_pkg::PWR_RUN;
		endcase
		stop_lp_nxt = (pwr_nxt == wdg_pkg::PWR_STOP);
	end

	always_ff @(posedge clk) begin
		if (wd_clr) begin
			pwr_r <= wdg_pkg::PWR_RUN;
			stop_lp_r <= 1'b0;
			stop_as_wait_r <= 1'b0;
		end else begin
			pwr_r <= pwr_nxt;
			stop_lp_r <= stop_lp_nxt;
			stop_as_wait_r <= stop_as_wait_nxt;
		end
	end

	// ---------------------------------------------------------------------
	// Sticky events; a new event wins over a clear in the same cycle.
	// They reset only with the external reset so that software can see,
	// after restarting, that the watchdog fired.
	always_comb begin
		ev = '0;
		ev[wdg_pkg::EV_TIMER] = ~active_r & msb_fall;
		ev[wdg_pkg::EV_WDRST] = fire_r;
		ev[wdg_pkg::EV_STOPWAIT] = stop_as_wait_nxt;
		stat_nxt = stat_r;
		if (wr_clr) begin
			stat_nxt = stat_nxt & ~wdata_r[2:0];
		end
		stat_nxt = stat_nxt | ev;
		en_nxt = wr_en ? wdata_r[2:0] : en_r;
		irq_nxt = |(stat_nxt & en_nxt);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			stat_r <= '0;
			en_r <= '0;
			irq_r <= 1'b0;
		end else begin
			stat_r <= stat_nxt;
			en_r <= en_nxt;
			irq_r <= irq_nxt;
		end
	end

endmodule : wdg_top

`default_nettype wire

// ==== test/wdg_top_assertions.sv ====
// Port-level checker for the watchdog top block, attached by bind.
// Assumes hw_option only changes while rst is high.
`timescale 1ns/1ps
`default_nettype none

module wdg_top_assertions #(
	parameter int DIV_INT = 12,
	parameter int DIV_PRE = 256,
	parameter int STAB_CYCLES = 2048
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic hw_option,
	input wire logic stop_req,
	input wire logic wake,
	input wire wdg_pkg::wdg_axi_req_s axi_req,
	input wire wdg_pkg::wdg_axi_rsp_s axi_rsp,
	input wire logic dev_rst_r,
	input wire logic irq_r,
	input wire logic stop_lp_r,
	input wire logic stop_as_wait_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	property p_rst_hold;
		$fell(rst) |-> dev_rst_r [*8];
	endproperty
	a_rst_hold: assert property (p_rst_hold)
		else $error("reset released too early");
	property p_fire_hold;
		$rose(dev_rst_r) |-> dev_rst_r [*8];
	endproperty
	a_fire_hold: assert property (p_fire_hold)
		else $error("watchdog reset too short");
	property p_hw_wait;
		stop_req && hw_option && !dev_rst_r |-> ##[1:2] stop_as_wait_r;
	endproperty
	a_hw_wait: assert property (p_hw_wait)
		else $error("stop not turned into wait");
	property p_wait_cause;
		stop_as_wait_r |-> $past(stop_req) && !stop_lp_r;
	endproperty
	a_wait_cause: assert property (p_wait_cause)
		else $error("wait pulse without stop");
	property p_lp_sw;
		stop_lp_r |-> !hw_option;
	endproperty
	a_lp_sw: assert property (p_lp_sw)
		else $error("low power stop under hw option");
	property p_lp_cause;
		$rose(stop_lp_r) |-> $past(stop_req) && !stop_as_wait_r;
	endproperty
	a_lp_cause: assert property (p_lp_cause)
		else $error("low power stop without request");
	property p_wake;
		stop_lp_r && wake |=> !stop_lp_r;
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake did not leave stop");
	property p_lp_hold;
		stop_lp_r && !wake |=> stop_lp_r;
	endproperty
	a_lp_hold: assert property (p_lp_hold)
		else $error("stop left without wake");
endmodule : wdg_top_assertions

bind wdg_top wdg_top_assertions #(
	.DIV_INT(DIV_INT), .DIV_PRE(DIV_PRE), .STAB_CYCLES(STAB_CYCLES)
) u_chk (
	.clk(clk), .rst(rst), .hw_option(hw_option), .stop_req(stop_req),
	.wake(wake), .axi_req(axi_req), .axi_rsp(axi_rsp),
	.dev_rst_r(dev_rst_r), .irq_r(irq_r), .stop_lp_r(stop_lp_r),
	.stop_as_wait_r(stop_as_wait_r)
);
`default_nettype wire

// ==== test/wdg_top_test.sv ====
// Self-checking bench for the watchdog top block.
// Assumes shortened dividers, so one count step takes 12 clocks.
`timescale 1ns/1ps
`default_nettype none

module wdg_top_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hw_option = 1'b0;
	logic stop_req = 1'b0;
	logic wake = 1'b0;
	wdg_pkg::wdg_axi_req_s req = '0;
	wdg_pkg::wdg_axi_rsp_s rsp;
	logic dev_rst, irq, lp, saw;
	logic [31:0] d, d0;
	logic [1:0] r;
	int n;
	int fail_count = 0;
	int n_checks = 0;

	wdg_top #(.DIV_INT(3), .DIV_PRE(4), .STAB_CYCLES(16)) u_dut (
		.clk(clk), .rst(rst), .hw_option(hw_option), .stop_req(stop_req),
		.wake(wake), .axi_req(req), .axi_rsp(rsp), .dev_rst_r(dev_rst),
		.irq_r(irq), .stop_lp_r(lp), .stop_as_wait_r(saw)
	);

	always #20 clk = ~clk;

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task print_verdict;
		if (fail_count == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	// Address and data are offered together and dropped one by one as taken.
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= v;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		do begin
			@(posedge clk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		r = rsp.bresp;
		req.bready <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a);
		@(posedge clk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do begin
			@(posedge clk);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 1'b0;
	endtask : rd

	task wait_rel;
		n = 0;
		while (dev_rst) begin
			@(posedge clk);
			n++;
		end
	endtask : wait_rel

	task wait_fire;
		n = 0;
		while (!dev_rst && n < 40) begin
			@(posedge clk);
			n++;
		end
	endtask : wait_fire

	task stop_pulse;
		@(posedge clk);
		stop_req <= 1'b1;
		@(posedge clk);
		stop_req <= 1'b0;
		n = 0;
		repeat (3) begin
			@(posedge clk);
			if (saw) n++;
		end
	endtask : stop_pulse

	task do_reset(input logic hw);
		@(posedge clk);
		hw_option <= hw;
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		wait_rel();
		chk(32'(n >= 16 && n <= 18), 32'h0000_0001);
		rd(8'hd8);
		chk(d, {24'h00_0000, 7'h7f, hw});
	endtask : do_reset

	// Inactive timer with reversed bits, its interrupt and bus refusals.
	task t_timer;
		wr(8'he4, 32'h0000_0001);
		wr(8'hd8, 32'h0000_0082);
		rd(8'hd8);
		chk(d, 32'h0000_0082);
		repeat (10) @(posedge clk);
		rd(8'hd8);
		chk(d, 32'h0000_0002);
		repeat (10) @(posedge clk);
		rd(8'hd8);
		chk(d, 32'h0000_00fc);
		chk(32'(irq), 32'h0000_0001);
		chk(32'(dev_rst), 32'h0000_0000);
		wr(8'he4, 32'h0000_0000);
		rd(8'hdc);
		chk(d, 32'h0000_0001);
		chk(32'(irq), 32'h0000_0000);
		wr(8'he4, 32'h0000_0001);
		rd(8'he4);
		chk(d, 32'h0000_0001);
		rd(8'hf0);
		chk(32'(r), 32'h0000_0002);
		chk(32'(irq), 32'h0000_0001);
		wr(8'he0, 32'h0000_0001);
		rd(8'he0);
		chk(d, 32'h0000_0000);
		chk(32'(r), 32'h0000_0000);
		wr(8'hdc, 32'h0000_0000);
		chk(32'(r), 32'h0000_0002);
		chk(32'(irq), 32'h0000_0000);
	endtask : t_timer

	task t_fire;
		wr(8'hd8, 32'h0000_00ff);
		wr(8'hd8, 32'h0000_00fe);
		rd(8'hd8);
		chk(d, 32'h0000_00ff);
		// Gaps longer in total than one full period prove the reloads work.
		repeat (4) begin
			repeat (250) @(posedge clk);
			wr(8'hd8, 32'h0000_00ff);
		end
		chk(32'(dev_rst), 32'h0000_0000);
		wr(8'hd8, 32'h0000_0003);
		wait_fire();
		chk(32'(n >= 13 && n <= 15), 32'h0000_0001);
		wait_rel();
		chk(32'(n >= 16), 32'h0000_0001);
		rd(8'hd8);
		chk(d, 32'h0000_00fe);
		rd(8'hdc);
		chk(d & 32'h0000_0002, 32'h0000_0002);
		wr(8'hd8, 32'h0000_00fd);
		wait_fire();
		chk(32'(n <= 3), 32'h0000_0001);
		wait_rel();
	endtask : t_fire

	task t_stop;
		stop_pulse();
		chk(32'(lp), 32'h0000_0001);
		rd(8'he8);
		chk(d, 32'h0000_0004);
		rd(8'hd8);
		d0 = d;
		repeat (30) @(posedge clk);
		rd(8'hd8);
		chk(d, d0);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		repeat (30) @(posedge clk);
		rd(8'hd8);
		chk(32'(d !== d0), 32'h0000_0001);
		wr(8'hd8, 32'h0000_00ff);
		stop_pulse();
		chk(32'(n), 32'h0000_0001);
		chk(32'(lp), 32'h0000_0000);
	endtask : t_stop

	task t_hw;
		wr(8'hd8, 32'h0000_00fe);
		rd(8'hd8);
		chk(d, 32'h0000_00ff);
		stop_pulse();
		chk(32'(n), 32'h0000_0001);
		rd(8'hdc);
		chk(d & 32'h0000_0004, 32'h0000_0004);
	endtask : t_hw

	initial begin
		repeat (6000) @(posedge clk);
		fail_count++;
		print_verdict();
	end

	initial begin
		do_reset(1'b0);
		t_timer();
		t_fire();
		t_stop();
		do_reset(1'b1);
		t_hw();
		print_verdict();
	end
endmodule : wdg_top_test
`default_nettype wire
